// [verilog/malc_pkg.sv]
// Package for the module access level control block.
// Holds descriptor and frame layouts, CPU-space map and field codes.
// Overview of operation
// R1 - Call saves state, return restores it
// R2 - Only option codes 000 and 100 accepted
// R3 - Option 000 copies arguments on stack change
// R4 - Option 100 stores caller stack pointer
// R5 - Only descriptor types 00 and 01
// R6 - Type 00 keeps rights, caller stack
// R7 - Level field used only for type 01
// R8 - Entry word selects saved register
// R9 - Stack change saves old, loads new
// R10 - Types 10 to 1F raise format error
// R11 - Stack register entry gets stack pointer
// R12 - Frame holds all listed fields
// R13 - Return checks frame option and type
// R14 - Return removes arguments by count
// R15 - CPU-space accesses with A19-A16 0001
// R16 - Bus error gives format error
// R17 - Hardware registers at 00,04,08,0C
// R18 - Level values are opaque to device
// R19 - Status code decides processor action
// R20 - Descriptor address written per function code
// R21 - Hardware judges legality of change
// R22 - Call sequence: level, probe, addr, raise, status
// R23 - Return writes lower level, reads status
// R24 - Denied change leaves registers untouched
// R25 - Hardware terminates cycles, data in top byte
package malc_pkg;
    // CPU-space map
    localparam logic [31:0] MALC_CPU_SPACE_BASE = 32'h0001_0000;
    localparam logic [7:0] MALC_OFF_CUR_LEVEL = 8'h00;
    localparam logic [7:0] MALC_OFF_STATUS = 8'h04;
    localparam logic [7:0] MALC_OFF_RAISE = 8'h08;
    localparam logic [7:0] MALC_OFF_LOWER = 8'h0C;
    localparam logic [7:0] MALC_OFF_DESC_BASE = 8'h10;
    localparam logic [2:0] MALC_FC_CPU = 3'h7;
    // Field codes
    localparam logic [2:0] MALC_OPT_STACK = 3'h0;
    localparam logic [2:0] MALC_OPT_POINTER = 3'h4;
    localparam logic [4:0] MALC_TYPE_PLAIN = 5'h00;
    localparam logic [4:0] MALC_TYPE_LEVEL = 5'h01;
    localparam int MALC_ENTRY_DA_BIT = 15;
    localparam int MALC_ENTRY_REG_HI = 14;
    localparam int MALC_ENTRY_REG_LO = 12;
    localparam logic [3:0] MALC_SP_REG = 4'hF;
    localparam int MALC_LEVEL_LSB = 24;

    typedef struct packed {
        logic [2:0] opt;
        logic [4:0] dtype;
        logic [7:0] level;
        logic [7:0] arg_count;
        logic [31:0] entry_ptr;
        logic [31:0] data_ptr;
        logic [31:0] stack_ptr;
    } malc_desc_s;

    typedef struct packed {
        logic [31:0] ret_pc;
        logic [2:0] opt;
        logic [4:0] dtype;
        logic [7:0] level;
        logic [7:0] arg_count;
        logic [7:0] condition_code_byte;
        logic [31:0] caller_sp;
        logic [31:0] saved_data_ptr;
        logic [31:0] desc_addr;
    } malc_frame_s;

    typedef struct packed {
        logic req;
        logic write;
        logic [2:0] fc;
        logic [31:0] addr;
        logic [31:0] wdata;
    } malc_bus_req_s;
endpackage

// [verilog/malc_status_dec.sv]
// Access status decoder for the level control block.
// Assumes the status byte was sampled from the top data lane.
`timescale 1ns/1ps
`default_nettype none
module malc_status_dec
    import malc_pkg::*;
(
    input wire logic [7:0] status_i,
    output logic fault_o,
    output logic change_o,
    output logic new_stack_o
);
    // R19 status code action
    always_comb begin
        fault_o = 1'b1;
        change_o = 1'b0;
        new_stack_o = 1'b0;
        if (status_i == 8'h01) begin
            fault_o = 1'b0;
        end else if (status_i == 8'h02 || status_i == 8'h03) begin
            fault_o = 1'b0;
            change_o = 1'b1;
        end else if (status_i >= 8'h04 && status_i <= 8'h07) begin
            fault_o = 1'b0;
            change_o = 1'b1;
            new_stack_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

// [verilog/malc_core.sv]
// Module call / return sequencer with access level handshake.
// Assumes an outer bus unit runs each request and answers with ack or
// bus error; memory reads and writes for frame and argument copy go there.
`timescale 1ns/1ps
`default_nettype none
module malc_core
    import malc_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    // Instruction start
    input wire logic call_start_i,
    input wire logic ret_start_i,
    input wire logic [31:0] desc_addr_i,
    input wire logic [2:0] desc_fc_i,
    input wire malc_desc_s desc_i,
    input wire malc_frame_s frame_i,
    input wire logic [15:0] entry_word_i,
    input wire logic [31:0] next_pc_i,
    input wire logic [7:0] ccr_i,
    input wire logic [31:0] sp_i,
    input wire logic [31:0] reg_file_val_i,
    // Bus unit
    output malc_bus_req_s bus_o,
    input wire logic bus_ack_i,
    input wire logic bus_error_input_i,
    input wire logic [31:0] bus_rdata_i,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic format_error_o,
    output malc_frame_s frame_o,
    output logic frame_wr_o,
    output logic [31:0] new_sp_o,
    output logic sp_wr_o,
    output logic [3:0] dst_reg_o,
    output logic [31:0] dst_val_o,
    output logic dst_wr_o,
    output logic [31:0] new_pc_o,
    output logic [7:0] ccr_o,
    output logic args_copy_o,
    output logic [7:0] args_remove_o
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CHECK = 4'b0001,
        ST_RD_LEVEL = 4'b0010,
        ST_PROBE = 4'b0011,
        ST_WR_DESC = 4'b0100,
        ST_WR_RAISE = 4'b0101,
        ST_WR_LOWER = 4'b0110,
        ST_RD_STATUS = 4'b0111,
        ST_COMMIT = 4'b1000,
        ST_FAULT = 4'b1001
    } malc_state_e;

    malc_state_e state_q, state_d;
    logic is_call_q;
    logic [7:0] cur_level_q;
    logic [7:0] status_q;
    logic st_fault, st_new_stack;
    logic fmt_ok;

    ////////////////////////////////////////////////////////////////////////
    // R2 option check
    // R5 type check
    function automatic logic fields_ok(input logic [2:0] opt, input logic [4:0] dtype);
        // R10 reserved types refused
        fields_ok = (opt == MALC_OPT_STACK || opt == MALC_OPT_POINTER) &&
                    (dtype == MALC_TYPE_PLAIN || dtype == MALC_TYPE_LEVEL);
    endfunction

    function automatic logic [31:0] cpu_addr(input logic [7:0] off);
        // R15 CPU-space address pattern
        cpu_addr = MALC_CPU_SPACE_BASE | {24'h00_0000, off};
    endfunction

    // R13 return frame check
    assign fmt_ok = is_call_q ? fields_ok(desc_i.opt, desc_i.dtype) :
                    fields_ok(frame_i.opt, frame_i.dtype);

    malc_status_dec u_status_dec (
        .status_i(status_q),
        .fault_o(st_fault),
        .change_o(),
        .new_stack_o(st_new_stack)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (call_start_i || ret_start_i) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!fmt_ok) begin
                    state_d = ST_FAULT;
                // R6 type 00 no handshake
                end else if (is_call_q && desc_i.dtype == MALC_TYPE_PLAIN) begin
                    state_d = ST_COMMIT;
                end else if (!is_call_q && frame_i.dtype == MALC_TYPE_PLAIN) begin
                    state_d = ST_COMMIT;
                // R22 call sequence start
                end else if (is_call_q) begin
                    state_d = ST_RD_LEVEL;
                // R23 return lowers level
                end else begin
                    state_d = ST_WR_LOWER;
                end
            end
            ST_RD_LEVEL: state_d = bus_error_input_i ? ST_FAULT : (bus_ack_i ? ST_PROBE : ST_RD_LEVEL);
            ST_PROBE: state_d = bus_error_input_i ? ST_FAULT : (bus_ack_i ? ST_WR_DESC : ST_PROBE);
            ST_WR_DESC: state_d = bus_error_input_i ? ST_FAULT : (bus_ack_i ? ST_WR_RAISE : ST_WR_DESC);
            ST_WR_RAISE: state_d = bus_error_input_i ? ST_FAULT : (bus_ack_i ? ST_RD_STATUS : ST_WR_RAISE);
            ST_WR_LOWER: state_d = bus_error_input_i ? ST_FAULT : (bus_ack_i ? ST_RD_STATUS : ST_WR_LOWER);
            // R16 bus error faults
            ST_RD_STATUS: state_d = bus_error_input_i ? ST_FAULT : (bus_ack_i ? ST_COMMIT : ST_RD_STATUS);
            // R24 denied change, no update
            ST_COMMIT: state_d = st_fault && (is_call_q ? desc_i.dtype : frame_i.dtype) == MALC_TYPE_LEVEL ?
                                 ST_FAULT : ST_IDLE;
            ST_FAULT: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Remember which instruction is running
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            is_call_q <= 1'b0;
        end else if (state_q == ST_IDLE && (call_start_i || ret_start_i)) begin
            is_call_q <= call_start_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampled level and status bytes, top lane only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_level_q <= 8'h00;
            status_q <= 8'h00;
        end else begin
            // R18 level kept opaque
            if (state_q == ST_RD_LEVEL && bus_ack_i) begin
                cur_level_q <= bus_rdata_i[31:MALC_LEVEL_LSB];
            end
            // Status 01 preloaded so a plain type never faults
            if (state_q == ST_CHECK) begin
                status_q <= 8'h01;
            end else if (state_q == ST_RD_STATUS && bus_ack_i) begin
                status_q <= bus_rdata_i[31:MALC_LEVEL_LSB];
            end
        end
    end

    // Bus request, CPU space except the probe, combinational handshake
    always_comb begin
        bus_o = '0;
        bus_o.fc = MALC_FC_CPU;
        case (state_q)
            ST_RD_LEVEL: begin
                bus_o.req = 1'b1;
                bus_o.addr = cpu_addr(MALC_OFF_CUR_LEVEL);
            end
            ST_PROBE: begin
                // Probe read in the caller's data space
                bus_o.req = 1'b1;
                bus_o.fc = desc_fc_i;
                bus_o.addr = sp_i;
            end
            ST_WR_DESC: begin
                // R20 descriptor address per code
                bus_o.req = 1'b1;
                bus_o.write = 1'b1;
                bus_o.addr = cpu_addr(MALC_OFF_DESC_BASE + {3'h0, desc_fc_i, 2'h0});
                bus_o.wdata = desc_addr_i;
            end
            ST_WR_RAISE: begin
                // R7 level field forwarded
                bus_o.req = 1'b1;
                bus_o.write = 1'b1;
                bus_o.addr = cpu_addr(MALC_OFF_RAISE);
                bus_o.wdata = {desc_i.level, 24'h00_0000};
            end
            ST_WR_LOWER: begin
                bus_o.req = 1'b1;
                bus_o.write = 1'b1;
                bus_o.addr = cpu_addr(MALC_OFF_LOWER);
                bus_o.wdata = {frame_i.level, 24'h00_0000};
            end
            ST_RD_STATUS: begin
                bus_o.req = 1'b1;
                bus_o.addr = cpu_addr(MALC_OFF_STATUS);
            end
            default: begin
                bus_o.req = 1'b0;
            end
        endcase
    end

    assign busy_o = state_q != ST_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Commit results: done, format error, argument copy and write-enable outputs are single-cycle strobes; value outputs hold
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
            format_error_o <= 1'b0;
            frame_o <= '0;
            frame_wr_o <= 1'b0;
            new_sp_o <= 32'h0000_0000;
            sp_wr_o <= 1'b0;
            dst_reg_o <= 4'h0;
            dst_val_o <= 32'h0000_0000;
            dst_wr_o <= 1'b0;
            new_pc_o <= 32'h0000_0000;
            ccr_o <= 8'h00;
            args_copy_o <= 1'b0;
            args_remove_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            format_error_o <= 1'b0;
            frame_wr_o <= 1'b0;
            sp_wr_o <= 1'b0;
            dst_wr_o <= 1'b0;
            args_copy_o <= 1'b0;
            if (state_q == ST_FAULT) begin
                format_error_o <= 1'b1;
            end else if (state_q == ST_COMMIT && state_d == ST_IDLE) begin
                done_o <= 1'b1;
                if (is_call_q) begin
                    // R1 save state in frame
                    // R12 frame contents
                    frame_wr_o <= 1'b1;
                    frame_o.ret_pc <= next_pc_i;
                    frame_o.opt <= desc_i.opt;
                    frame_o.dtype <= desc_i.dtype;
                    frame_o.level <= cur_level_q;
                    frame_o.arg_count <= desc_i.arg_count;
                    frame_o.condition_code_byte <= ccr_i;
                    // R4 caller stack stored
                    frame_o.caller_sp <= sp_i;
                    frame_o.saved_data_ptr <= reg_file_val_i;
                    frame_o.desc_addr <= desc_addr_i;
                    new_pc_o <= desc_i.entry_ptr + 32'h0000_0002;
                    // R8 entry word register select
                    dst_reg_o <= {entry_word_i[MALC_ENTRY_DA_BIT],
                                  entry_word_i[MALC_ENTRY_REG_HI:MALC_ENTRY_REG_LO]};
                    dst_wr_o <= 1'b1;
                    // R9 new stack from descriptor
                    // R11 stack register gets stack value
                    if (desc_i.dtype == MALC_TYPE_LEVEL && st_new_stack) begin
                        sp_wr_o <= 1'b1;
                        new_sp_o <= desc_i.stack_ptr;
                        // R3 copy arguments to new stack
                        args_copy_o <= desc_i.opt == MALC_OPT_STACK;
                        dst_val_o <= {entry_word_i[MALC_ENTRY_DA_BIT],
                                      entry_word_i[MALC_ENTRY_REG_HI:MALC_ENTRY_REG_LO]} == MALC_SP_REG ?
                                     desc_i.stack_ptr : desc_i.data_ptr;
                    end else begin
                        dst_val_o <= {entry_word_i[MALC_ENTRY_DA_BIT],
                                      entry_word_i[MALC_ENTRY_REG_HI:MALC_ENTRY_REG_LO]} == MALC_SP_REG ?
                                     sp_i : desc_i.data_ptr;
                    end
                end else begin
                    // R1 restore from frame
                    new_pc_o <= frame_i.ret_pc;
                    ccr_o <= frame_i.condition_code_byte;
                    dst_reg_o <= {entry_word_i[MALC_ENTRY_DA_BIT],
                                  entry_word_i[MALC_ENTRY_REG_HI:MALC_ENTRY_REG_LO]};
                    dst_val_o <= frame_i.saved_data_ptr;
                    dst_wr_o <= 1'b1;
                    // R14 remove arguments by count
                    args_remove_o <= frame_i.arg_count;
                    if (frame_i.dtype == MALC_TYPE_LEVEL) begin
                        sp_wr_o <= 1'b1;
                        new_sp_o <= frame_i.caller_sp;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [dv/malc_core_properties.sv]
// Checker for the module call/return sequencer, bound to malc_core.
// Assumes it sees only the sequencer ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module malc_core_properties
    import malc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic call_start_i,
    input wire malc_desc_s desc_i,
    input wire malc_bus_req_s bus_o,
    input wire logic bus_ack_i,
    input wire logic bus_error_input_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic format_error_o,
    input wire logic frame_wr_o,
    input wire logic sp_wr_o,
    input wire logic dst_wr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic go;
    // Start accepted only when idle
    assign go = call_start_i && !busy_o;
    ////////////////////////////////////////////////////////////////
    property p_plain;
        go && desc_i.dtype == 5'h00 && desc_i.opt == 3'h0 |-> ##1 (!bus_o.req)[*2] ##1 done_o;
    endproperty
    property p_type;
        go && desc_i.dtype > 5'h01 |-> ##[1:3] format_error_o;
    endproperty
    property p_opt;
        go && desc_i.opt != 3'h0 && desc_i.opt != 3'h4 |-> ##[1:3] format_error_o;
    endproperty
    property p_space;
        bus_o.req && bus_o.fc == MALC_FC_CPU |-> bus_o.addr[19:16] == 4'h1;
    endproperty
    property p_hold;
        bus_o.req && !bus_ack_i && !bus_error_input_i |=> $stable(bus_o);
    endproperty
    property p_bus_error_input;
        bus_o.req && bus_error_input_i |-> ##[1:4] format_error_o;
    endproperty
    property p_deny;
        format_error_o |-> !frame_wr_o && !sp_wr_o && !dst_wr_o && !done_o;
    endproperty
    property p_first;
        go && desc_i.dtype == 5'h01 && desc_i.opt == 3'h4
            |-> ##[1:4] (bus_o.req && !bus_o.write && bus_o.addr == MALC_CPU_SPACE_BASE);
    endproperty
    a_plain: assert property (p_plain)
        else $error("plain call timing wrong");
    a_type: assert property (p_type)
        else $error("bad type accepted");
    a_opt: assert property (p_opt)
        else $error("bad option accepted");
    a_space: assert property (p_space)
        else $error("cpu space address wrong");
    a_hold: assert property (p_hold)
        else $error("request changed before answer");
    a_bus_error_input: assert property (p_bus_error_input)
        else $error("bus error not reported");
    a_deny: assert property (p_deny)
        else $error("state written on fault");
    a_first: assert property (p_first)
        else $error("level read not first");
    c_bus_error_input: cover property (bus_o.req && bus_error_input_i);
    c_write: cover property (bus_o.req && bus_o.write && bus_ack_i);
    c_done: cover property (done_o);
endmodule
bind malc_core malc_core_properties chk (.*);
`default_nettype wire

// [dv/malc_ahw_model.sv]
// Model of the external access control hardware on the CPU-space bus.
// Assumes requests hold until answered; level bytes are opaque.
`timescale 1ns/1ps
`default_nettype none
module malc_ahw_model
    import malc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire malc_bus_req_s bus_i,
    input wire logic [7:0] status_i,
    input wire logic [1:0] dly_i,
    input wire logic err_en_i,
    output logic ack_o,
    output logic err_o,
    output logic [31:0] rdata_o,
    output logic [7:0] raise_o,
    output logic [7:0] lower_o,
    output logic [31:0] daddr_o,
    output logic [7:0] cur_o
);
    logic [1:0] wait_q;
    logic go;
    logic ok;
    // Answer after the programmed wait, never twice
    assign go = bus_i.req && !ack_o && !err_o && wait_q == dly_i;
    assign ok = status_i >= 8'h02 && status_i < 8'h08;
    ////////////////////////////////////////////////////////////////
    // answer with byte in top lane
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            rdata_o <= 32'h0;
            wait_q <= 2'h0;
        end else begin
            ack_o <= go && !err_en_i;
            err_o <= go && err_en_i;
            wait_q <= (bus_i.req && !go && !ack_o && !err_o) ? wait_q + 2'h1 : 2'h0;
            // Idle lanes toggle so stale data is never mistaken
            rdata_o <= ~rdata_o;
            if (go && !bus_i.write)
                rdata_o <= bus_i.fc != MALC_FC_CPU ? 32'hC3C3_C3C3 :
                    bus_i.addr[2] ? {status_i, 24'hFFFFFF} : {cur_o, 24'hFFFFFF};
        end
    end
    // request registers, level kept when refused
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            raise_o <= 8'h00;
            lower_o <= 8'h00;
            daddr_o <= 32'h0;
            cur_o <= 8'h21;
        end else if (go && bus_i.write && !err_en_i) begin
            if (bus_i.addr[7:0] >= MALC_OFF_DESC_BASE)
                daddr_o <= bus_i.wdata;
            else if (bus_i.addr[2])
                lower_o <= bus_i.wdata[31:24];
            else
                raise_o <= bus_i.wdata[31:24];
            if (bus_i.addr[7:0] < MALC_OFF_DESC_BASE && ok)
                cur_o <= bus_i.wdata[31:24];
        end
    end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the module call/return sequencer.
// Assumes the hardware model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import malc_pkg::*;
();
    logic clk_i = 0;
    logic nrst_i = 0;
    logic call_start_i = 0;
    logic ret_start_i = 0;
    logic [31:0] desc_addr_i = 32'h0000_4000;
    logic [2:0] desc_fc_i = 3'h5;
    malc_desc_s desc_i = '0;
    malc_frame_s frame_i = '0;
    logic [15:0] entry_word_i = 16'hA000;
    logic [31:0] next_pc_i = 32'h0000_1234;
    logic [7:0] ccr_i = 8'h15;
    logic [31:0] sp_i = 32'h0000_8000;
    logic [31:0] reg_file_val_i = 32'h0000_0ABC;
    logic [7:0] status = 8'h05;
    logic [1:0] dly = 2'h2;
    logic err_en = 0;
    malc_bus_req_s bus_o;
    malc_frame_s frame_o;
    logic bus_ack_i, bus_error_input_i, busy_o, done_o, format_error_o;
    logic [31:0] bus_rdata_i, new_sp_o, dst_val_o, new_pc_o, daddr;
    logic [7:0] ccr_o, args_remove_o, raise, lower, cur;
    logic [3:0] dst_reg_o;
    logic fe, spw, copy;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////
    malc_core dut (.clk_i(clk_i), .nrst_i(nrst_i), .call_start_i(call_start_i),
        .ret_start_i(ret_start_i), .desc_addr_i(desc_addr_i), .desc_fc_i(desc_fc_i),
        .desc_i(desc_i), .frame_i(frame_i), .entry_word_i(entry_word_i), .next_pc_i(next_pc_i),
        .ccr_i(ccr_i), .sp_i(sp_i), .reg_file_val_i(reg_file_val_i), .bus_o(bus_o),
        .bus_ack_i(bus_ack_i), .bus_error_input_i(bus_error_input_i), .bus_rdata_i(bus_rdata_i),
        .busy_o(busy_o), .done_o(done_o), .format_error_o(format_error_o), .frame_o(frame_o),
        .frame_wr_o(), .new_sp_o(new_sp_o), .sp_wr_o(spw), .dst_reg_o(dst_reg_o),
        .dst_val_o(dst_val_o), .dst_wr_o(), .new_pc_o(new_pc_o), .ccr_o(ccr_o),
        .args_copy_o(copy), .args_remove_o(args_remove_o));
    malc_ahw_model hw (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_o), .status_i(status),
        .dly_i(dly), .err_en_i(err_en), .ack_o(bus_ack_i), .err_o(bus_error_input_i),
        .rdata_o(bus_rdata_i), .raise_o(raise), .lower_o(lower), .daddr_o(daddr), .cur_o(cur));
    // Clock and hang guard
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One start pulse, then wait for either ending
    task automatic run(input logic call);
        @(negedge clk_i);
        call_start_i = call;
        ret_start_i = !call;
        @(negedge clk_i);
        call_start_i = 0;
        ret_start_i = 0;
        for (int k = 0; k < 60 && done_o !== 1'b1 && format_error_o !== 1'b1; k++)
            @(negedge clk_i);
        fe = format_error_o;
        chk("ended", done_o | format_error_o, 1);
    endtask
    task automatic t_plain();
        desc_i = '{3'h0, 5'h00, 8'h77, 8'h02, 32'h2000, 32'h3000, 32'h9000};
        run(1);
        chk("fault", fe, 0);
        chk("dst", dst_reg_o, 4'hA);
        chk("dval", dst_val_o, 32'h3000);
        chk("pc", new_pc_o, 32'h2002);
        chk("retpc", frame_o.ret_pc, next_pc_i);
        chk("ccr", frame_o.condition_code_byte, ccr_i);
        chk("saved", frame_o.saved_data_ptr, reg_file_val_i);
        chk("daddr", frame_o.desc_addr, desc_addr_i);
        chk("argc", frame_o.arg_count, 8'h02);
        chk("raise", raise, 0);
        $display("plain call finished");
    endtask
    task automatic t_bad();
        logic [4:0] typ [4] = '{5'h02, 5'h03, 5'h10, 5'h1F};
        logic [2:0] opt [4] = '{3'h1, 3'h2, 3'h5, 3'h7};
        for (int i = 0; i < 4; i++) begin
            desc_i.opt = 3'h0;
            desc_i.dtype = typ[i];
            run(1);
            chk("type", fe, 1);
            desc_i.dtype = 5'h00;
            desc_i.opt = opt[i];
            run(1);
            chk("opt", fe, 1);
        end
        $display("bad codes finished");
    endtask
    task automatic t_level();
        desc_i = '{3'h4, 5'h01, 8'h5C, 8'h02, 32'h2000, 32'h3000, 32'h9000};
        run(1);
        chk("fault", fe, 0);
        chk("raise", raise, 8'h5C);
        chk("desc", daddr, desc_addr_i);
        chk("level", frame_o.level, 8'h21);
        chk("newsp", new_sp_o, 32'h9000);
        chk("callsp", frame_o.caller_sp, sp_i);
        chk("copy", copy, 0);
        desc_i.opt = 3'h0;
        entry_word_i = 16'hF000;
        run(1);
        chk("copy", copy, 1);
        chk("spw", spw, 1);
        chk("spreg", dst_reg_o, 4'hF);
        chk("spval", dst_val_o, 32'h9000);
        entry_word_i = 16'hA000;
        $display("level call finished");
    endtask
    task automatic t_deny();
        logic [7:0] bad [3] = '{8'h00, 8'h08, 8'hFF};
        for (int i = 0; i < 3; i++) begin
            status = bad[i];
            run(1);
            chk("deny", fe, 1);
            chk("cur", cur, 8'h5C);
        end
        status = 8'h01;
        err_en = 1;
        run(1);
        chk("bus_error_input", fe, 1);
        err_en = 0;
        $display("refusals finished");
    endtask
    task automatic t_ret();
        frame_i = '{32'h5550, 3'h0, 5'h01, 8'h33, 8'h06, 8'h04, 32'h7000, 32'h6000, 32'h4000};
        status = 8'h02;
        run(0);
        chk("fault", fe, 0);
        chk("lower", lower, 8'h33);
        chk("args", args_remove_o, 8'h06);
        chk("pc", new_pc_o, 32'h5550);
        chk("ccr", ccr_o, 8'h04);
        chk("retsp", new_sp_o, 32'h7000);
        frame_i.dtype = 5'h02;
        run(0);
        chk("ftype", fe, 1);
        $display("return finished");
    endtask
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        nrst_i = 1;
        t_plain();
        t_bad();
        t_level();
        t_deny();
        t_ret();
        complete_run();
    end
endmodule
`default_nettype wire
